// ### bench/async_serial_mp_uart_bench.sv
`timescale 1ns/1ps
module async_serial_mp_uart_bench
  import serial_unit_pkg::*;
;
  logic [ADDR_W-1:0] regAddr = 3'h0;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        regWrData = 8'h00;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [7:0]        regRdData;
  logic [7:0]        d;
  logic              rxd, txd, sckOut, sckOeN;
  logic              sckIn = 1'b0;
  logic              txEmptyIrq, txDoneIrq, rxFullIrq, rxFaultIrq;
  int                fails = 0;
  int                numChecks = 0;
  int                cycles = 0;
  always #4 ref_clk = ~ref_clk;
  // Never stopped, so external-clock mode always has its ticks
  always @(posedge ref_clk) sckIn <= ~sckIn;
  async_serial_mp_uart dut_u (
    .ref_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .rxd, .txd, .sckIn, .sckOut, .sckOeN,
    .txEmptyIrq, .txDoneIrq, .rxFullIrq, .rxFaultIrq
  );
  remote_node far_u (.ref_clk, .lineIn(txd), .lineOut(rxd));
  // ----------
  // Bus and compare tasks
  // ----------
  task automatic cmp(input logic [11:0] g, input logic [11:0] e);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic chk(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    cmp(d, e);
  endtask
  task automatic waitQ(input int n);
    repeat (800) begin
      if (far_u.got.size() >= n) break;
      @(posedge ref_clk);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    chk(ADDR_FMT, FMT_RST);
    chk(ADDR_DIV, DIV_RST);
    chk(ADDR_CTL, CTL_RST);
    chk(ADDR_STS, 8'h84);
    wr(ADDR_RXH, 8'h5A);
    chk(ADDR_RXH, DATA_RST);
    wr(3'h6, 8'hFF);
    chk(3'h6, 8'h00);
  endtask
  task automatic t_tx;
    wr(ADDR_CTL, 8'h01);
    wr(ADDR_FMT, 8'h20);
    wr(ADDR_DIV, 8'h00);
    repeat (16) @(posedge ref_clk);
    wr(ADDR_CTL, 8'hF5);
    wr(ADDR_TXH, 8'hA7);
    wr(ADDR_STS, 8'h7E);
    repeat (40) begin
      rd(ADDR_STS);
      if (d[STS_TX_HOLDING_EMPTY] === 1'b1) break;
    end
    cmp(d[STS_TX_HOLDING_EMPTY], 1'b1);
    cmp(txEmptyIrq, 1'b1);
    wr(ADDR_TXH, 8'h3C);
    wr(ADDR_STS, 8'h7E);
    waitQ(2);
    cmp(far_u.got[0], {3'h1, ^8'hA7, 8'hA7});
    cmp(far_u.got[1], {3'h1, ^8'h3C, 8'h3C});
    repeat (20) @(posedge ref_clk);
    #1 cmp(txDoneIrq, 1'b1);
    chk(ADDR_STS, 8'h84);
  endtask
  task automatic t_rx;
    far_u.sendBits({3'h1, 1'b0, 8'hC3}, 10);
    #1 cmp(rxFullIrq, 1'b1);
    chk(ADDR_STS, 8'hC4);
    chk(ADDR_RXH, 8'hC3);
    wr(ADDR_CTL, 8'hE5);
    chk(ADDR_STS, 8'hC4);
    wr(ADDR_CTL, 8'hF5);
    far_u.sendBits({3'h1, 1'b0, 8'h11}, 10);
    chk(ADDR_STS, 8'hE4);
    chk(ADDR_RXH, 8'hC3);
    cmp(rxFaultIrq, 1'b1);
    wr(ADDR_STS, 8'h84);
    far_u.sendBits({3'h1, 1'b1, 8'h0F}, 10);
    chk(ADDR_STS, 8'h8C);
    chk(ADDR_RXH, 8'h0F);
    far_u.sendBits({3'h1, 1'b0, 8'h22}, 10);
    chk(ADDR_RXH, 8'h0F);
    wr(ADDR_STS, 8'h84);
    far_u.sendBits({3'h0, 1'b0, 8'h44}, 10);
    chk(ADDR_STS, 8'h94);
    chk(ADDR_RXH, 8'h44);
    wr(ADDR_STS, 8'h84);
  endtask
  task automatic t_mp;
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_FMT, 8'h04);
    repeat (16) @(posedge ref_clk);
    wr(ADDR_CTL, 8'hFD);
    far_u.sendBits({3'h1, 1'b0, 8'h99}, 10);
    chk(ADDR_STS, 8'h84);
    far_u.sendBits({3'h1, 1'b1, 8'h42}, 10);
    chk(ADDR_STS, 8'hC6);
    chk(ADDR_CTL, 8'hF5);
    chk(ADDR_RXH, 8'h42);
    wr(ADDR_TXH, 8'h5A);
    wr(ADDR_STS, 8'h7F);
    waitQ(3);
    cmp(far_u.got[2], {3'h1, 1'b1, 8'h5A});
  endtask
  task automatic t_fmt;
    time t0;
    wr(ADDR_CTL, 8'h01);
    wr(ADDR_FMT, 8'h78);
    repeat (16) @(posedge ref_clk);
    wr(ADDR_CTL, 8'h31);
    wr(ADDR_TXH, 8'hB1);
    wr(ADDR_STS, 8'h3E);
    far_u.sendBits(12'h331, 10);
    waitQ(4);
    cmp(far_u.got[3], 12'h331);
    chk(ADDR_STS, 8'hC4);
    chk(ADDR_RXH, 8'h31);
    wr(ADDR_CTL, 8'h02);
    repeat (32) @(posedge ref_clk);
    wr(ADDR_CTL, 8'h22);
    wr(ADDR_TXH, 8'h01);
    wr(ADDR_STS, 8'h7E);
    @(negedge txd) t0 = $time;
    @(posedge txd);
    cmp(12'(($time - t0) >> 3), 12'h020);
  endtask
  task automatic t_abort;
    wr(ADDR_TXH, 8'h00);
    wr(ADDR_STS, 8'h7E);
    wr(ADDR_TXH, 8'h81);
    wr(ADDR_STS, 8'h7E);
    repeat (30) @(posedge ref_clk);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_STS);
    cmp(d[STS_TX_HOLDING_EMPTY], 1'b1);
    cmp(txd, 1'b1);
  endtask
  // A hang counts as a mismatch and still reaches the report
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_mp();
    t_fmt();
    t_abort();
    tally_and_finish();
  end
endmodule

// ### bench/remote_node.sv
`timescale 1ns/1ps
module remote_node (
  input  wire logic ref_clk,
  input  wire logic lineIn,
  output logic      lineOut
);
  // Bit time is 16 clocks: the bench keeps the divisor at 0
  logic [11:0] got[$];
  logic [11:0] w;
  initial lineOut = 1'b1;
  task automatic sendBits(input logic [11:0] b, input int n);
    @(posedge ref_clk);
    lineOut <= 1'b0;
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      lineOut <= b[i];
      repeat (16) @(posedge ref_clk);
    end
    lineOut <= 1'b1;
    repeat (16) @(posedge ref_clk);
  endtask
  // Sample 1ns after the edge so the registered line has settled
  always begin
    @(negedge lineIn);
    w = 12'h000;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge ref_clk);
      #1 w[i] = lineIn;
    end
    got.push_back(w);
  end
endmodule

// ### bench/uart_sva.sv
`timescale 1ns/1ps
module uart_sva
  import serial_unit_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [7:0]        regRdData,
  input wire logic              txd,
  input wire logic              sckOut,
  input wire logic              sckOeN,
  input wire logic              txEmptyIrq,
  input wire logic              txDoneIrq,
  input wire logic              rxFullIrq,
  input wire logic              rxFaultIrq
);
  // ----------
  // Shadow settings
  // ----------
  logic [7:0]  ctl_ff;
  logic [7:0]  div_ff;
  logic [15:0] lowRun_ff;
  logic [12:0] bitLen;
  assign bitLen = {div_ff + 9'h001, 4'h0};
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_ff    <= CTL_RST;
      div_ff    <= DIV_RST;
      lowRun_ff <= 16'h0000;
    end else begin
      if (regWrite && regAddr == ADDR_CTL) ctl_ff <= regWrData;
      if (regWrite && regAddr == ADDR_DIV) div_ff <= regWrData;
      lowRun_ff <= txd ? 16'h0000 : lowRun_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence ctlWr;
    regWrite && regAddr == ADDR_CTL;
  endsequence
  chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not zero");
  chk_rd_unmapped: assert property (
    regRead && regAddr > ADDR_RXH |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_txoff_mark: assert property (
    ctlWr ##0 !regWrData[CTL_TXON] |-> ##2 txd)
    else $error("txd not at mark");
  chk_clkout_on: assert property (
    ctlWr ##0 regWrData[1:0] == CKS_INTOUT |-> ##2 !sckOeN)
    else $error("clock pin not driven");
  chk_clkout_off: assert property (
    ctlWr ##0 regWrData[1:0] != CKS_INTOUT |-> ##2 sckOeN)
    else $error("clock pin driven");
  // An aborted frame is cut mid bit, so only enabled frames are measured
  chk_bit_length: assert property (
    ctl_ff[CTL_TXON] && $rose(txd) |->
      lowRun_ff % {3'h0, bitLen} == 16'h0000)
    else $error("low run not whole bits");
  chk_sck_centre: assert property (
    !sckOeN && div_ff == 8'h00 && $changed(txd) |-> ##[6:10] $rose(sckOut))
    else $error("clock not rising mid bit");
  chk_tie_gate: assert property (
    !ctl_ff[CTL_TIE] && !$past(ctl_ff[CTL_TIE]) |-> !txEmptyIrq)
    else $error("empty irq while disabled");
  chk_tx_done_irq_enable_gate: assert property (
    !ctl_ff[CTL_TX_DONE_IRQ_ENABLE] && !$past(ctl_ff[CTL_TX_DONE_IRQ_ENABLE]) |-> !txDoneIrq)
    else $error("done irq while disabled");
  chk_rie_full: assert property (
    !ctl_ff[CTL_RIE] && !$past(ctl_ff[CTL_RIE]) |-> !rxFullIrq)
    else $error("full irq while disabled");
  chk_rie_fault: assert property (
    !ctl_ff[CTL_RIE] && !$past(ctl_ff[CTL_RIE]) |-> !rxFaultIrq)
    else $error("fault irq while disabled");
endmodule
bind async_serial_mp_uart uart_sva chk_u (
  .ref_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData, .txd, .sckOut, .sckOeN, .txEmptyIrq, .txDoneIrq,
  .rxFullIrq, .rxFaultIrq
);

// ### core/async_serial_mp_uart.sv
// How it works
// - Clearing transmit-on sets holding-empty and returns the shifter to idle.
// - Clearing receive-on keeps receive flags and receive holding data.
// - Clock-out selection drives the clock pin two clocks after it is written.
// - Holding-empty cleared means new data; it is copied into the shifter.
// - After loading, holding-empty sets, frame starts, empty interrupt if enabled.
// - Frame opens with one zero start bit, then 7 or 8 bits LSB first.
// - Then parity, multiprocessor bit, or nothing; parity unused in MP formats.
// - One or two stop ones end the frame; line idles high.
// - At the stop bit a cleared holding-empty loads the next frame.
// - Otherwise done flag sets, line idles, done interrupt if enabled.
// - Receiver finds the start bit, shifts data LSB first, then parity, stop.
// - Count of ones in data and parity must match odd/even selection.
// - First stop bit must be one; a second one is not checked.
// - Data moves to holding only if full is clear; clean frames set full.
// - Frame ending with full still set flags overrun and drops data.
// - Bad stop or parity sets its fault yet still moves the data.
// - Any fault stops reception, full cannot set until faults cleared.
// - Receive enable gates full and fault interrupts.
// - Multiprocessor bit sent equals the software transmit value.
// - Receivers skip until an ID character; software matches the ID.
// - Start synchronised on the falling edge; bits sampled on eighth tick.
// - Output clock runs at bit rate, rising in each bit centre.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module async_serial_mp_uart
  import serial_unit_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [7:0]        regRdData,
  input  wire logic              rxd,
  output logic                   txd,
  input  wire logic              sckIn,
  output logic                   sckOut,
  output logic                   sckOeN,
  output logic                   txEmptyIrq,
  output logic                   txDoneIrq,
  output logic                   rxFullIrq,
  output logic                   rxFaultIrq
);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [7:0]  frameFormatReg_ff;
  logic [7:0]  bitRateDivisor_ff;
  logic [7:0]  serialControlReg_ff;
  logic [7:0]  txHolding_ff;
  logic [7:0]  rxHolding_ff;
  logic [7:0]  regRdData_ff;
  logic        txHoldingEmpty_ff;
  logic        rxHoldingFull_ff;
  logic        overrunFault_ff;
  logic        framingFault_ff;
  logic        parityFault_ff;
  logic        txDoneFlag_ff;
  logic        mpFlagBit_ff;
  logic        mpTxBitValue_ff;
  logic        txEmptyIrq_ff;
  logic        txDoneIrq_ff;
  logic        rxFullIrq_ff;
  logic        rxFaultIrq_ff;

  txState_type txState_ff;
  logic [7:0]  txShifter_ff;
  logic [3:0]  txBitCnt_ff;
  logic        txExtra_ff;
  logic        txNext_ff;
  logic        txd_ff;

  rxState_type rxState_ff;
  logic [7:0]  rxShifter_ff;
  logic [3:0]  rxBitCnt_ff;
  logic [3:0]  rxSub_ff;
  logic        rxExtra_ff;
  logic        rxdPrev_ff;

  tick_if tk ();

  serial_clock_gen u_clk (
    .ref_clk (ref_clk),
    .reset   (reset),
    .divisor (bitRateDivisor_ff),
    .clkSel  (serialControlReg_ff[CTL_CKS+1:CTL_CKS]),
    .sckIn   (sckIn),
    .tk      (tk.gen)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wrFmt = regWrite && (regAddr == ADDR_FMT);
  wire wrDiv = regWrite && (regAddr == ADDR_DIV);
  wire wrCtl = regWrite && (regAddr == ADDR_CTL);
  wire wrTxh = regWrite && (regAddr == ADDR_TXH);
  wire wrSts = regWrite && (regAddr == ADDR_STS);

  wire txOn      = serialControlReg_ff[CTL_TXON];
  wire rxOn      = serialControlReg_ff[CTL_RXON];
  wire idWait    = serialControlReg_ff[CTL_IDW];
  wire chr7      = frameFormatReg_ff[FMT_CHR7];
  wire mpFmt     = frameFormatReg_ff[FMT_MP];
  wire parOn     = frameFormatReg_ff[FMT_PAR_ON] & ~mpFmt;
  wire oddSel    = frameFormatReg_ff[FMT_ODD];
  wire stop2     = frameFormatReg_ff[FMT_STOP2];
  wire extraOn   = parOn | mpFmt;
  wire [3:0] dataBits = chr7 ? BITS_7 : BITS_8;

  wire bitTick   = tk.tick16 && (tk.phase == PHASE_LAST);
  wire anyFault  = overrunFault_ff | framingFault_ff | parityFault_ff;

  // ------------------------------------------------------------
  // Transmit control
  // ------------------------------------------------------------
  wire txLastData = (txBitCnt_ff == dataBits);
  wire enterStop  = bitTick && (((txState_ff == TX_DATA) &&
                    txLastData && !extraOn) || (txState_ff == TX_PAR));
  // Holding register is only checked in idle and at the stop bit
  wire txLoad     = txOn && !txHoldingEmpty_ff &&
                    ((txState_ff == TX_IDLE) || enterStop);
  wire txDoneSet  = txOn && txHoldingEmpty_ff && enterStop;
  wire [7:0] txData = chr7 ? {1'h0, txHolding_ff[6:0]} : txHolding_ff;
  wire txParity   = ^txData ^ oddSel;

  // ------------------------------------------------------------
  // Receive control
  // ------------------------------------------------------------
  wire rxAllowed = rxOn && !anyFault;
  wire rxFall    = rxdPrev_ff & ~rxd;
  wire rxSample  = tk.tick16 && (rxSub_ff == SAMPLE_PHASE);
  wire rxDone    = rxAllowed && rxSample && (rxState_ff == RX_STOP);
  wire rxDiscard = rxDone && mpFmt && idWait && !rxExtra_ff;
  wire rxAccept  = rxDone && !rxDiscard;
  wire idClear   = rxAccept && mpFmt && idWait;
  wire fErr      = ~rxd;
  wire pErr      = parOn &&
                   ((^{rxShifter_ff, rxExtra_ff}) != oddSel);
  wire rxXfer    = rxAccept && !rxHoldingFull_ff;
  wire orSet     = rxAccept && rxHoldingFull_ff;
  wire ferSet    = rxXfer && fErr;
  wire perSet    = rxXfer && pErr;
  wire rdrfSet   = rxXfer && !fErr && !pErr;

  // ------------------------------------------------------------
  // Status flags: a hardware set wins over a software clear
  // ------------------------------------------------------------
  wire clrTdre = wrSts && !regWrData[STS_TX_HOLDING_EMPTY];
  wire clrRdrf = wrSts && !regWrData[STS_RX_HOLDING_FULL];
  wire clrOrf  = wrSts && !regWrData[STS_ORF];
  wire clrFrf  = wrSts && !regWrData[STS_FRF];
  wire clrPrf  = wrSts && !regWrData[STS_PRF];
  wire clrTend = wrSts && !regWrData[STS_TX_DONE_FLAG];
  wire setTdre = txLoad || !txOn;

  wire [7:0] statusView = {txHoldingEmpty_ff, rxHoldingFull_ff,
                           overrunFault_ff, framingFault_ff,
                           parityFault_ff, txDoneFlag_ff,
                           mpFlagBit_ff, mpTxBitValue_ff};

  wire [7:0] rdMux =
    (regAddr == ADDR_FMT) ? frameFormatReg_ff   :
    (regAddr == ADDR_DIV) ? bitRateDivisor_ff   :
    (regAddr == ADDR_CTL) ? serialControlReg_ff :
    (regAddr == ADDR_TXH) ? txHolding_ff        :
    (regAddr == ADDR_STS) ? statusView          :
    (regAddr == ADDR_RXH) ? rxHolding_ff        : DATA_RST;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frameFormatReg_ff   <= FMT_RST;
      bitRateDivisor_ff   <= DIV_RST;
      serialControlReg_ff <= CTL_RST;
      txHolding_ff        <= DATA_RST;
      mpTxBitValue_ff     <= 1'h0;
      regRdData_ff        <= DATA_RST;
    end else begin
      if (wrFmt)
        frameFormatReg_ff <= regWrData;
      if (wrDiv)
        bitRateDivisor_ff <= regWrData;
      if (wrCtl)
        serialControlReg_ff <= regWrData;
      else if (idClear)
        serialControlReg_ff[CTL_IDW] <= 1'h0;
      if (wrTxh)
        txHolding_ff <= regWrData;
      if (wrSts)
        mpTxBitValue_ff <= regWrData[STS_MPT];
      regRdData_ff <= regRead ? rdMux : DATA_RST;
    end
  end

  // Receive-on plays no part here, so turning it off keeps them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txHoldingEmpty_ff <= 1'h1;
      rxHoldingFull_ff  <= 1'h0;
      overrunFault_ff   <= 1'h0;
      framingFault_ff   <= 1'h0;
      parityFault_ff    <= 1'h0;
      txDoneFlag_ff     <= 1'h1;
    end else begin
      txHoldingEmpty_ff <= setTdre | (txHoldingEmpty_ff & ~clrTdre);
      rxHoldingFull_ff  <= rdrfSet | (rxHoldingFull_ff & ~clrRdrf);
      overrunFault_ff   <= orSet | (overrunFault_ff & ~clrOrf);
      framingFault_ff   <= ferSet | (framingFault_ff & ~clrFrf);
      parityFault_ff    <= perSet | (parityFault_ff & ~clrPrf);
      txDoneFlag_ff     <= txDoneSet |
                           (txDoneFlag_ff & ~clrTend & ~txLoad);
    end
  end

  // Receive holding register and its multiprocessor flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxHolding_ff <= DATA_RST;
      mpFlagBit_ff <= 1'h0;
    end else if (rxXfer) begin
      rxHolding_ff <= rxShifter_ff;
      mpFlagBit_ff <= rxExtra_ff & mpFmt;
    end
  end

  // ------------------------------------------------------------
  // Interrupt request levels
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txEmptyIrq_ff <= 1'h0;
      txDoneIrq_ff  <= 1'h0;
      rxFullIrq_ff  <= 1'h0;
      rxFaultIrq_ff <= 1'h0;
    end else begin
      txEmptyIrq_ff <= serialControlReg_ff[CTL_TIE] &
                       txHoldingEmpty_ff;
      txDoneIrq_ff  <= serialControlReg_ff[CTL_TX_DONE_IRQ_ENABLE] &
                       txDoneFlag_ff;
      rxFullIrq_ff  <= serialControlReg_ff[CTL_RIE] &
                       rxHoldingFull_ff;
      rxFaultIrq_ff <= serialControlReg_ff[CTL_RIE] & anyFault;
    end
  end

  // ------------------------------------------------------------
  // Transmitter: bit boundaries follow the shared 16x phase
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txState_ff   <= TX_IDLE;
      txShifter_ff <= DATA_RST;
      txBitCnt_ff  <= 4'h0;
      txExtra_ff   <= 1'h0;
      txNext_ff    <= 1'h0;
      txd_ff       <= 1'h1;
    end else if (!txOn) begin
      txState_ff <= TX_IDLE;
      txNext_ff  <= 1'h0;
      txd_ff     <= 1'h1;
    end else begin
      if (txLoad) begin
        txShifter_ff <= txData;
        txExtra_ff   <= mpFmt ? mpTxBitValue_ff : txParity;
      end
      case (txState_ff)
        TX_IDLE: begin
          if (txLoad)
            txState_ff <= TX_WAIT;
        end
        TX_WAIT: begin
          if (bitTick) begin
            txState_ff <= TX_START;
            txd_ff     <= 1'h0;
          end
        end
        TX_START: begin
          if (bitTick) begin
            txState_ff  <= TX_DATA;
            txd_ff      <= txShifter_ff[0];
            txBitCnt_ff <= 4'h1;
          end
        end
        TX_DATA: begin
          if (bitTick) begin
            if (!txLastData) begin
              txd_ff      <= txShifter_ff[txBitCnt_ff[2:0]];
              txBitCnt_ff <= txBitCnt_ff + 4'h1;
            end else if (extraOn) begin
              txState_ff <= TX_PAR;
              txd_ff     <= txExtra_ff;
            end else begin
              txState_ff <= TX_STOP1;
              txd_ff     <= 1'h1;
              txNext_ff  <= txLoad;
            end
          end
        end
        TX_PAR: begin
          if (bitTick) begin
            txState_ff <= TX_STOP1;
            txd_ff     <= 1'h1;
            txNext_ff  <= txLoad;
          end
        end
        TX_STOP1, TX_STOP2: begin
          if (bitTick) begin
            if (stop2 && (txState_ff == TX_STOP1)) begin
              txState_ff <= TX_STOP2;
            end else if (txNext_ff) begin
              txState_ff <= TX_START;
              txd_ff     <= 1'h0;
              txNext_ff  <= 1'h0;
            end else begin
              txState_ff <= TX_IDLE;
            end
          end
        end
        default: begin
          txState_ff <= TX_IDLE;
          txd_ff     <= 1'h1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receiver: samples on the eighth 16x tick after the edge
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxState_ff   <= RX_IDLE;
      rxShifter_ff <= DATA_RST;
      rxBitCnt_ff  <= 4'h0;
      rxSub_ff     <= 4'h0;
      rxExtra_ff   <= 1'h0;
      rxdPrev_ff   <= 1'h1;
    end else begin
      rxdPrev_ff <= rxd;
      if (tk.tick16)
        rxSub_ff <= rxSub_ff + 4'h1;
      if (!rxAllowed) begin
        rxState_ff <= RX_IDLE;
      end else begin
        case (rxState_ff)
          RX_IDLE: begin
            if (rxFall) begin
              rxState_ff <= RX_START;
              rxSub_ff   <= 4'h0;
            end
          end
          RX_START: begin
            if (rxSample) begin
              // A high level at mid start bit was a glitch
              rxState_ff   <= rxd ? RX_IDLE : RX_DATA;
              rxBitCnt_ff  <= 4'h0;
              rxShifter_ff <= DATA_RST;
              rxExtra_ff   <= 1'h0;
            end
          end
          RX_DATA: begin
            if (rxSample) begin
              rxShifter_ff[rxBitCnt_ff[2:0]] <= rxd;
              rxBitCnt_ff <= rxBitCnt_ff + 4'h1;
              if (rxBitCnt_ff == dataBits - 4'h1)
                rxState_ff <= extraOn ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: begin
            if (rxSample) begin
              rxExtra_ff <= rxd;
              rxState_ff <= RX_STOP;
            end
          end
          RX_STOP: begin
            // Only the first stop bit is looked at
            if (rxSample)
              rxState_ff <= RX_IDLE;
          end
          default: begin
            rxState_ff <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign regRdData  = regRdData_ff;
  assign txd        = txd_ff;
  assign sckOut     = tk.sckOut;
  assign sckOeN     = tk.sckOeN;
  assign txEmptyIrq = txEmptyIrq_ff;
  assign txDoneIrq  = txDoneIrq_ff;
  assign rxFullIrq  = rxFullIrq_ff;
  assign rxFaultIrq = rxFaultIrq_ff;

endmodule

// ### core/serial_clock_gen.sv
`timescale 1ns/1ps
module serial_clock_gen
  import serial_unit_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] divisor,
  input  wire logic [1:0] clkSel,
  input  wire logic       sckIn,
  tick_if.gen             tk
);

  logic [7:0] divCnt_ff;
  logic       sckInPrev_ff;
  logic       tick16_ff;
  logic [3:0] phase_ff;
  logic       sckOut_ff;
  logic       sckOeN_ff;

  wire divHit  = (divCnt_ff == divisor);
  wire extTick = sckIn & ~sckInPrev_ff;
  // External 16x clock on the pin, otherwise the internal divider
  wire nxt_tick = clkSel[1] ? extTick : divHit;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      divCnt_ff    <= 8'h00;
      sckInPrev_ff <= 1'h0;
      tick16_ff    <= 1'h0;
      phase_ff     <= 4'h0;
      sckOut_ff    <= 1'h0;
      sckOeN_ff    <= 1'h1;
    end else begin
      divCnt_ff    <= divHit ? 8'h00 : divCnt_ff + 8'h01;
      sckInPrev_ff <= sckIn;
      tick16_ff    <= nxt_tick;
      if (tick16_ff)
        phase_ff <= phase_ff + 4'h1;
      // High from mid bit to bit end: rising edge in the bit centre
      sckOut_ff <= phase_ff[3];
      sckOeN_ff <= (clkSel != CKS_INTOUT);
    end
  end

  assign tk.tick16 = tick16_ff;
  assign tk.phase  = phase_ff;
  assign tk.sckOut = sckOut_ff;
  assign tk.sckOeN = sckOeN_ff;

endmodule

// ### core/serial_unit_pkg.sv
package serial_unit_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int         ADDR_W   = 3;
  localparam logic [2:0] ADDR_FMT = 3'h0;
  localparam logic [2:0] ADDR_DIV = 3'h1;
  localparam logic [2:0] ADDR_CTL = 3'h2;
  localparam logic [2:0] ADDR_TXH = 3'h3;
  localparam logic [2:0] ADDR_STS = 3'h4;
  localparam logic [2:0] ADDR_RXH = 3'h5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FMT_CHR7   = 6;
  localparam int FMT_PAR_ON = 5;
  localparam int FMT_ODD    = 4;
  localparam int FMT_STOP2  = 3;
  localparam int FMT_MP     = 2;

  localparam int CTL_TIE  = 7;
  localparam int CTL_RIE  = 6;
  localparam int CTL_TXON = 5;
  localparam int CTL_RXON = 4;
  localparam int CTL_IDW  = 3;
  localparam int CTL_TX_DONE_IRQ_ENABLE = 2;
  localparam int CTL_CKS  = 0;

  localparam int STS_TX_HOLDING_EMPTY = 7;
  localparam int STS_RX_HOLDING_FULL = 6;
  localparam int STS_ORF  = 5;
  localparam int STS_FRF  = 4;
  localparam int STS_PRF  = 3;
  localparam int STS_TX_DONE_FLAG = 2;
  localparam int STS_MPB  = 1;
  localparam int STS_MPT  = 0;

  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] FMT_RST    = 8'h00;
  localparam logic [7:0] DIV_RST    = 8'hFF;
  localparam logic [7:0] CTL_RST    = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [1:0] CKS_INTOUT = 2'h1;

  // ------------------------------------------------------------
  // Timing counts in 16x ticks and bits
  // ------------------------------------------------------------
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] PHASE_LAST   = 4'hF;
  localparam logic [3:0] BITS_7       = 4'h7;
  localparam logic [3:0] BITS_8       = 4'h8;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_WAIT  = 3'h1,
    TX_START = 3'h2,
    TX_DATA  = 3'h3,
    TX_PAR   = 3'h4,
    TX_STOP1 = 3'h5,
    TX_STOP2 = 3'h6
  } txState_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4
  } rxState_type;

endpackage

// ### core/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic       tick16;
  logic [3:0] phase;
  logic       sckOut;
  logic       sckOeN;
  modport gen  (output tick16, phase, sckOut, sckOeN);
  modport core (input  tick16, phase, sckOut, sckOeN);
endinterface
